// >>> src/rbw_pkg.sv
/*
  Shared constants and types for the RAM back-up and wakeup controller.
  Assumes a 4-bit register port driven by the CPU core's transfer instructions.
*/
`default_nettype none

package rbw_pkg;

  // Widths
  localparam int DATA_W        = 4;
  localparam int ADDR_W        = 4;
  localparam int PC_W          = 13;
  localparam int STACK_W       = 3;
  localparam int NUM_WAKE_PINS = 10;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_KEY_EN   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_P0_COND  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_EXT_WAKE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PU0      = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PU1      = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EXT0_CTL = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_EXT1_CTL = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h7;

  // Values after reset
  localparam logic [DATA_W-1:0] CTRL_RESET = 4'h0;

  // Field positions
  localparam int EXT_POL_BIT     = 0;
  localparam int EXT_GATE_BIT    = 1;
  localparam int STAT_FLAG_BIT   = 0;
  localparam int STAT_BACKUP_BIT = 1;
  localparam int STAT_ARMED_BIT  = 2;

  // Restart values
  localparam logic [PC_W-1:0]    RESTART_PC       = 13'h0000;
  localparam logic [STACK_W-1:0] STACK_INIT_LEVEL = 3'h7;

  // Controller states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_BACKUP = 3'b010,
    ST_WAKE   = 3'b100
  } rbw_state_t;

endpackage

`default_nettype wire

// >>> src/rbw_wake_det.sv
/*
  One wakeup input qualifier: level or edge, either polarity.
  Assumes the pin is synchronous to ref_clk and that ref_clk keeps running in back-up.
*/
`default_nettype none

module rbw_wake_det (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic arm,
  input  wire logic pinLevel,
  input  wire logic enable,
  input  wire logic edgeMode,
  input  wire logic activeHigh,
  output logic      hit
);

  logic prevReg;
  logic prevNext;

  // Previous level follows the pin on every cycle with ce high
  always_comb begin
    prevNext = pinLevel;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prevReg <= 1'b1;
    end else if (ce) begin
      prevReg <= prevNext;
    end
  end

  // Qualified event while armed
  always_comb begin
    hit = 1'b0;
    if (enable && arm) begin
      if (edgeMode) begin
        hit = activeHigh ? (!prevReg && pinLevel) : (prevReg && !pinLevel);
      end else begin
        hit = (pinLevel == activeHigh);
      end
    end
  end

endmodule

`default_nettype wire

// >>> src/ram_backup_wakeup_control.sv
/*
  RAM back-up entry, retention, wakeup and warm/cold start control.
  Assumes the core reports each executed instruction with a one-cycle strobe,
  that ref_clk stays alive in back-up while oscStop halts the system clock,
  and that all pins are synchronous to ref_clk.
*/
`default_nettype none

module ram_backup_wakeup_control (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        ce,
  input  wire logic [rbw_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [rbw_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [rbw_pkg::DATA_W-1:0]  regRdata,
  input  wire logic                        instrDone,
  input  wire logic                        poweroffEnableInstr,
  input  wire logic                        poweroffInstr,
  input  wire logic                        softwareResetInstr,
  input  wire logic                        skipIfBackupFlagInstr,
  input  wire logic                        watchdogReset,
  input  wire logic                        voltageDrop,
  input  wire logic                        voltageDetectEnablePin,
  input  wire logic [3:0]                  port0Pins,
  input  wire logic [3:0]                  port1Pins,
  input  wire logic                        extIrqPinZero,
  input  wire logic                        extIrqPinOne,
  output logic                             skipTaken,
  output logic                             backupFlag,
  output logic                             inBackup,
  output logic                             oscStop,
  output logic                             warmRestart,
  output logic                             coldRestart,
  output logic      [rbw_pkg::PC_W-1:0]    restartPc,
  output logic      [rbw_pkg::STACK_W-1:0] stackLevelInit,
  output logic                             watchdogInit,
  output logic                             extReqSuppress,
  output logic                             extIrqInZero,
  output logic                             extIrqInOne,
  output logic      [3:0]                  port0Pullup,
  output logic      [3:0]                  port1Pullup
);

  import rbw_pkg::*;

  rbw_state_t          stateReg;
  rbw_state_t          stateNext;
  logic                armedReg;
  logic                armedNext;
  logic                flagReg;
  logic                flagNext;
  logic                warmReg;
  logic                warmNext;
  logic                coldReg;
  logic                coldNext;
  logic                wdInitReg;
  logic                wdInitNext;
  logic [PC_W-1:0]     pcReg;
  logic [PC_W-1:0]     pcNext;
  logic [DATA_W-1:0]   keyEnReg;
  logic [DATA_W-1:0]   keyEnNext;
  logic [DATA_W-1:0]   p0CondReg;
  logic [DATA_W-1:0]   p0CondNext;
  logic [DATA_W-1:0]   extWakeReg;
  logic [DATA_W-1:0]   extWakeNext;
  logic [DATA_W-1:0]   pu0Reg;
  logic [DATA_W-1:0]   pu0Next;
  logic [DATA_W-1:0]   pu1Reg;
  logic [DATA_W-1:0]   pu1Next;
  logic [DATA_W-1:0]   ext0CtlReg;
  logic [DATA_W-1:0]   ext0CtlNext;
  logic [DATA_W-1:0]   ext1CtlReg;
  logic [DATA_W-1:0]   ext1CtlNext;
  logic [DATA_W-1:0]   rdataReg;
  logic [DATA_W-1:0]   rdataNext;
  logic                enterBackup;
  logic                coldEvent;
  logic                anyHit;
  logic [NUM_WAKE_PINS-1:0] wakePin;
  logic [NUM_WAKE_PINS-1:0] wakeEn;
  logic [NUM_WAKE_PINS-1:0] wakeEdge;
  logic [NUM_WAKE_PINS-1:0] wakeHigh;
  logic [NUM_WAKE_PINS-1:0] wakeHit;

  // Entry and cold-start decode
  always_comb begin
    enterBackup = instrDone && poweroffInstr && armedReg && (stateReg == ST_RUN);
    coldEvent = watchdogReset || (voltageDrop && voltageDetectEnablePin) ||
                (instrDone && softwareResetInstr);
  end

  // Per-pin wakeup configuration
  always_comb begin
    wakePin = {extIrqPinOne, extIrqPinZero, port1Pins, port0Pins};
    wakeEn[1:0]   = {2{keyEnReg[0]}};
    wakeEn[3:2]   = {2{keyEnReg[1]}};
    wakeEdge[1:0] = {2{p0CondReg[1]}};
    wakeEdge[3:2] = {2{p0CondReg[3]}};
    wakeHigh[1:0] = {2{p0CondReg[0]}};
    wakeHigh[3:2] = {2{p0CondReg[2]}};
    wakeEn[5:4]   = {2{keyEnReg[2]}};
    wakeEn[7:6]   = {2{keyEnReg[3]}};
    wakeEdge[7:4] = 4'h0;
    wakeHigh[7:4] = 4'h0;
    wakeEn[8]     = extWakeReg[0];
    wakeEdge[8]   = extWakeReg[1];
    wakeHigh[8]   = ext0CtlReg[EXT_POL_BIT];
    wakeEn[9]     = extWakeReg[2];
    wakeEdge[9]   = extWakeReg[3];
    wakeHigh[9]   = ext1CtlReg[EXT_POL_BIT];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAKE_PINS; gi++) begin : gWake
      rbw_wake_det uDet (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .ce         (ce),
        .arm        (stateReg == ST_BACKUP),
        .pinLevel   (wakePin[gi]),
        .enable     (wakeEn[gi]),
        .edgeMode   (wakeEdge[gi]),
        .activeHigh (wakeHigh[gi]),
        .hit        (wakeHit[gi])
      );
    end
  endgenerate
  assign anyHit = |wakeHit;

  // Sequencer next state
  always_comb begin
    stateNext  = stateReg;
    armedNext  = armedReg;
    flagNext   = flagReg;
    warmNext   = 1'b0;
    coldNext   = 1'b0;
    wdInitNext = 1'b0;
    pcNext     = pcReg;
    // enable only arms the very next instruction
    if (instrDone) begin
      armedNext = poweroffEnableInstr;
    end
    if (coldEvent) begin
      stateNext = ST_RUN;
      flagNext  = 1'b0;
      coldNext  = 1'b1;
      armedNext = 1'b0;
      pcNext    = RESTART_PC;
    end else begin
      unique case (stateReg)
        ST_RUN: begin
          if (enterBackup) begin
            stateNext  = ST_BACKUP;
            flagNext   = 1'b1;
            wdInitNext = 1'b1;
            armedNext  = 1'b0;
          end
        end
        ST_BACKUP: begin
          if (anyHit) begin
            stateNext = ST_WAKE;
            warmNext  = 1'b1;
            pcNext    = RESTART_PC;
          end
        end
        ST_WAKE: begin
          stateNext = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stateReg  <= ST_RUN;
      armedReg  <= 1'b0;
      flagReg   <= 1'b0;
      warmReg   <= 1'b0;
      coldReg   <= 1'b0;
      wdInitReg <= 1'b0;
      pcReg     <= RESTART_PC;
    end else if (ce) begin
      stateReg  <= stateNext;
      armedReg  <= armedNext;
      flagReg   <= flagNext;
      warmReg   <= warmNext;
      coldReg   <= coldNext;
      wdInitReg <= wdInitNext;
      pcReg     <= pcNext;
    end
  end

  // Control register writes; back-up never touches them
  always_comb begin
    keyEnNext   = keyEnReg;
    p0CondNext  = p0CondReg;
    extWakeNext = extWakeReg;
    pu0Next     = pu0Reg;
    pu1Next     = pu1Reg;
    ext0CtlNext = ext0CtlReg;
    ext1CtlNext = ext1CtlReg;
    if (regWr) begin
      unique case (regAddr)
        OFS_KEY_EN:   keyEnNext   = regWdata;
        OFS_P0_COND:  p0CondNext  = regWdata;
        OFS_EXT_WAKE: extWakeNext = regWdata;
        OFS_PU0:      pu0Next     = regWdata;
        OFS_PU1:      pu1Next     = regWdata;
        OFS_EXT0_CTL: ext0CtlNext = regWdata;
        OFS_EXT1_CTL: ext1CtlNext = regWdata;
        default: ;
      endcase
    end
  end

  // Read mux, data valid the cycle after the strobe only
  always_comb begin
    rdataNext = CTRL_RESET;
    if (regRd) begin
      unique case (regAddr)
        OFS_KEY_EN:   rdataNext = keyEnReg;
        OFS_P0_COND:  rdataNext = p0CondReg;
        OFS_EXT_WAKE: rdataNext = extWakeReg;
        OFS_PU0:      rdataNext = pu0Reg;
        OFS_PU1:      rdataNext = pu1Reg;
        OFS_EXT0_CTL: rdataNext = ext0CtlReg;
        OFS_EXT1_CTL: rdataNext = ext1CtlReg;
        OFS_STATUS: begin
          rdataNext[STAT_FLAG_BIT]   = flagReg;
          rdataNext[STAT_BACKUP_BIT] = (stateReg == ST_BACKUP);
          rdataNext[STAT_ARMED_BIT]  = armedReg;
        end
        default: rdataNext = CTRL_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      keyEnReg   <= CTRL_RESET;
      p0CondReg  <= CTRL_RESET;
      extWakeReg <= CTRL_RESET;
      pu0Reg     <= CTRL_RESET;
      pu1Reg     <= CTRL_RESET;
      ext0CtlReg <= CTRL_RESET;
      ext1CtlReg <= CTRL_RESET;
      rdataReg   <= CTRL_RESET;
    end else if (ce) begin
      keyEnReg   <= keyEnNext;
      p0CondReg  <= p0CondNext;
      extWakeReg <= extWakeNext;
      pu0Reg     <= pu0Next;
      pu1Reg     <= pu1Next;
      ext0CtlReg <= ext0CtlNext;
      ext1CtlReg <= ext1CtlNext;
      rdataReg   <= rdataNext;
    end
  end

  assign skipTaken      = instrDone && skipIfBackupFlagInstr && flagReg;
  assign backupFlag     = flagReg;
  assign inBackup       = (stateReg == ST_BACKUP);
  assign oscStop        = (stateReg == ST_BACKUP);
  // warm pulse inits core; timers untouched
  assign warmRestart    = warmReg;
  assign coldRestart    = coldReg;
  assign restartPc      = pcReg;
  assign stackLevelInit = STACK_INIT_LEVEL;
  assign watchdogInit   = wdInitReg;
  assign extReqSuppress = (stateReg != ST_RUN);
  assign extIrqInZero   = extIrqPinZero && ext0CtlReg[EXT_GATE_BIT];
  assign extIrqInOne    = extIrqPinOne && ext1CtlReg[EXT_GATE_BIT];
  assign port0Pullup    = pu0Reg;
  assign port1Pullup    = pu1Reg;
  assign regRdata       = rdataReg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_enter_armed;
    $rose(inBackup) |-> $past(armedReg) && $past(instrDone && poweroffInstr);
  endproperty
  a_enter_armed: assert property (p_enter_armed) else $error("back-up entered without arm");
  property p_poweroff_nop;
    (ce && stateReg == ST_RUN && instrDone && poweroffInstr && !armedReg) |=> !inBackup;
  endproperty
  a_poweroff_nop: assert property (p_poweroff_nop) else $error("unarmed power-off acted");
  property p_warm_flag;
    warmRestart |-> backupFlag && restartPc == RESTART_PC && $past(inBackup);
  endproperty
  a_warm_flag: assert property (p_warm_flag) else $error("warm restart bad flag or pc");
  property p_cold_clear;
    (ce && coldEvent) |=> !backupFlag && coldRestart && restartPc == RESTART_PC;
  endproperty
  a_cold_clear: assert property (p_cold_clear) else $error("cold start left flag set");
  property p_retain;
    (ce && inBackup && !regWr) |=> $stable(keyEnReg) && $stable(p0CondReg) && $stable(pu0Reg);
  endproperty
  a_retain: assert property (p_retain) else $error("register lost in back-up");
  property p_wd_init;
    $rose(inBackup) |-> watchdogInit ##1 !watchdogInit;
  endproperty
  a_wd_init: assert property (p_wd_init) else $error("watchdog not initialized");
  property p_vd_pin;
    (ce && voltageDrop && !voltageDetectEnablePin && !watchdogReset && !(instrDone && softwareResetInstr))
      |=> !coldRestart;
  endproperty
  a_vd_pin: assert property (p_vd_pin) else $error("detector acted while disabled");
  property p_stay;
    (ce && inBackup && !anyHit && !coldEvent) |=> inBackup;
  endproperty
  a_stay: assert property (p_stay) else $error("back-up left without wakeup");
  property p_suppress;
    (inBackup || warmRestart) |-> extReqSuppress;
  endproperty
  a_suppress: assert property (p_suppress) else $error("request flag not suppressed");
  property p_flag_set;
    $rose(inBackup) |-> backupFlag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on entry");

endmodule

`default_nettype wire

// >>> verif/rbw_key_model.sv
/*
  Keys and signal sources on the wakeup pins, as seen from the board.
  Assumes the bench calls setPins; released keys read high through pull-ups.
*/
`default_nettype none

module rbw_key_model (
  input  wire logic       ref_clk,
  output var  logic [3:0] port0Pins,
  output var  logic [3:0] port1Pins,
  output var  logic       extIrqPinZero,
  output var  logic       extIrqPinOne
);
  timeunit 1ns;
  timeprecision 1ns;

  // All keys released at start
  // port1 held high
  initial begin
    port0Pins = 4'hF;
    port1Pins = 4'hF;
    extIrqPinZero = 1'b1;
    extIrqPinOne = 1'b1;
  end

  // Press or release after a chosen lag, just after an edge
  // levels suit mode
  task automatic setPins(input logic [3:0] p0, input logic [3:0] p1, input logic [1:0] ei, input int lag);
    repeat (lag) @(posedge ref_clk);
    @(posedge ref_clk);
    port0Pins <= p0;
    port1Pins <= p1;
    {extIrqPinOne, extIrqPinZero} <= ei;
  endtask

endmodule

`default_nettype wire

// >>> verif/tb_ram_backup_wakeup_control.sv
/*
  Self-checking bench for the RAM back-up and wakeup controller.
  Assumes rbw_pkg and rbw_key_model are compiled first; ce is high except in one freeze check.
*/
`default_nettype none

module tb_ram_backup_wakeup_control;
  timeunit 1ns;
  timeprecision 1ns;
  import rbw_pkg::*;

  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic               ce = 1'b1;
  logic               voltageDetectEnablePin = 1'b0;
  logic               watchdogReset = 1'b0;
  logic               voltageDrop = 1'b0;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic               instrDone = 1'b0;
  logic [3:0]         qual = 4'h0;
  logic [ADDR_W-1:0]  regAddr = 4'h0;
  logic [DATA_W-1:0]  regWdata = 4'h0;
  logic [DATA_W-1:0]  regRdata, port0Pullup, port1Pullup;
  logic [3:0]         port0Pins, port1Pins;
  logic               extIrqPinZero, extIrqPinOne;
  logic               skipTaken, backupFlag, inBackup, oscStop, warmRestart, coldRestart;
  logic               watchdogInit, extReqSuppress, extIrqInZero, extIrqInOne;
  logic [PC_W-1:0]    restartPc;
  logic [STACK_W-1:0] stackLevelInit;
  int                 n_fail = 0;
  int                 compares = 0;
  int                 cycles = 0;
  // Nibbles: keyEn p0Cond extWake ctl0 ctl1 preP0 preInt wakeP0 wakeP1 wakeInt
  logic [39:0]        cases [9] = '{40'h40000F3FE3, 40'h20000F3BF3, 40'h13000E3FF3, 40'h12000F3DF3,
                                    40'h11000C3DF3, 40'h00110F2FF3, 40'h00C01F1FF3, 40'h00100F3FF2, 40'h00C00F3FF1};

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  ram_backup_wakeup_control dut_u (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .instrDone(instrDone),
    .poweroffEnableInstr(qual[3]), .poweroffInstr(qual[2]), .softwareResetInstr(qual[1]),
    .skipIfBackupFlagInstr(qual[0]), .watchdogReset(watchdogReset), .voltageDrop(voltageDrop),
    .voltageDetectEnablePin(voltageDetectEnablePin), .port0Pins(port0Pins), .port1Pins(port1Pins),
    .extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne), .skipTaken(skipTaken),
    .backupFlag(backupFlag), .inBackup(inBackup), .oscStop(oscStop), .warmRestart(warmRestart),
    .coldRestart(coldRestart), .restartPc(restartPc), .stackLevelInit(stackLevelInit),
    .watchdogInit(watchdogInit), .extReqSuppress(extReqSuppress), .extIrqInZero(extIrqInZero),
    .extIrqInOne(extIrqInOne), .port0Pullup(port0Pullup), .port1Pullup(port1Pullup)
  );

  rbw_key_model keys_u (
    .ref_clk(ref_clk), .port0Pins(port0Pins), .port1Pins(port1Pins),
    .extIrqPinZero(extIrqPinZero), .extIrqPinOne(extIrqPinOne)
  );

  // Compare with four-state equality and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One-cycle register write
  task automatic bus_wr(input logic [3:0] a, input logic [3:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask

  // One-cycle register read; data taken in the following cycle
  task automatic bus_rd(input logic [3:0] a, output logic [3:0] d);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // One executed instruction; qualifiers {enable, poweroff, swreset, skip}
  task automatic instr(input logic [3:0] q, output logic sk);
    @(posedge ref_clk);
    instrDone <= 1'b1;
    qual <= q;
    #1 sk = skipTaken;
    @(posedge ref_clk);
    instrDone <= 1'b0;
    qual <= 4'h0;
    #1;
  endtask

  // Cold or reset event {detectEnable, reset, watchdog, drop}; checks {cold, flag, inBackup}
  task automatic evt(input logic [3:0] e, input logic [2:0] exp);
    @(posedge ref_clk);
    {voltageDetectEnablePin, reset, watchdogReset, voltageDrop} <= e;
    @(posedge ref_clk);
    {voltageDetectEnablePin, reset, watchdogReset, voltageDrop} <= {e[3], 3'b000};
    #1 chk("coldState", 16'(exp), 16'({coldRestart, backupFlag, inBackup}));
  endtask

  task automatic enter_bk;
    logic sk;
    instr(4'h8, sk);
    instr(4'h4, sk);
    chk("entry", 16'hF, 16'({inBackup, oscStop, backupFlag, watchdogInit}));
    @(posedge ref_clk);
    #1 chk("entryLater", 16'hE, 16'({inBackup, oscStop, backupFlag, watchdogInit}));
  endtask

  // Reset values, read-back, read-only status, unmapped place, pin gating
  task automatic t_regs;
    logic [3:0] d;
    for (int a = 0; a < 8; a++) begin
      bus_rd(4'(a), d);
      chk("resetValue", 16'h0, 16'(d));
    end
    for (int a = 0; a < 7; a++) begin
      bus_wr(4'(a), 4'(a + 9));
      bus_rd(4'(a), d);
      chk("readBack", 16'(a + 9), 16'(d));
    end
    chk("pullups", 16'h00CD, 16'({port0Pullup, port1Pullup}));
    // Write with the clock enable low must not land
    @(posedge ref_clk);
    ce <= 1'b0;
    bus_wr(OFS_PU0, 4'h5);
    chk("ceFreeze", 16'hC, 16'(port0Pullup));
    @(posedge ref_clk);
    ce <= 1'b1;
    chk("extGate", 16'h3, 16'({extIrqInZero, extIrqInOne}));
    bus_wr(OFS_EXT0_CTL, 4'h1);
    chk("extGateOff", 16'h1, 16'({extIrqInZero, extIrqInOne}));
    bus_wr(OFS_STATUS, 4'hF);
    bus_rd(OFS_STATUS, d);
    chk("statusReadOnly", 16'h0, 16'(d));
    bus_wr(4'h9, 4'hF);
    bus_rd(4'h9, d);
    chk("unmapped", 16'h0, 16'(d));
    @(posedge ref_clk);
    #1 chk("rdataIdle", 16'h0, 16'(regRdata));
  endtask

  // Power-off without a directly preceding enable does nothing
  task automatic t_poweroff;
    logic sk;
    logic [3:0] d;
    instr(4'h1, sk);
    chk("skipCold", 16'h0, 16'(sk));
    instr(4'h4, sk);
    chk("lonePoweroff", 16'h0, 16'(inBackup));
    instr(4'h8, sk);
    bus_rd(OFS_STATUS, d);
    chk("statusArmed", 16'h4, 16'(d));
    instr(4'h0, sk);
    instr(4'h4, sk);
    chk("splitPair", 16'h0, 16'(inBackup));
  endtask

  // Nine wakeup cases over port0, port1 pins 4-5 and both external pins, with a disabled pair pressed first
  task automatic t_wake;
    logic [39:0] c;
    logic [3:0] d;
    logic seen;
    logic sk;
    for (int i = 0; i < 9; i++) begin
      c = cases[i];
      keys_u.setPins(c[19:16], 4'hF, c[13:12], 0);
      bus_wr(OFS_KEY_EN, c[39:36]);
      bus_wr(OFS_P0_COND, c[35:32]);
      bus_wr(OFS_EXT_WAKE, c[31:28]);
      bus_wr(OFS_EXT0_CTL, c[27:24]);
      bus_wr(OFS_EXT1_CTL, c[23:20]);
      enter_bk();
      keys_u.setPins(c[19:16], 4'h7, c[13:12], 0);
      repeat (3) @(posedge ref_clk);
      #1 chk("ignoredPin", 16'h1, 16'(inBackup));
      keys_u.setPins(c[11:8], c[7:4] & 4'h7, c[1:0], i % 3);
      seen = 1'b0;
      for (int k = 0; k < 8 && seen !== 1'b1; k++) begin
        @(posedge ref_clk);
        #1 seen = warmRestart;
      end
      chk("warmRestart", 16'h1, 16'(seen));
      chk("restartPc", 16'h0, 16'(restartPc));
      chk("stackLevel", 16'h7, 16'(stackLevelInit));
      chk("warmFlags", 16'h3, 16'({inBackup, backupFlag, extReqSuppress}));
      @(posedge ref_clk);
      #1 chk("afterWake", 16'h0, 16'({warmRestart, extReqSuppress}));
      instr(4'h1, sk);
      chk("skipWarm", 16'h1, 16'(sk));
      bus_rd(OFS_EXT_WAKE, d);
      chk("retained", 16'(c[31:28]), 16'(d));
    end
  endtask

  // Cold starts clear the flag; detector obeys only its enable pin
  task automatic t_cold;
    logic sk;
    logic [3:0] d;
    bus_wr(OFS_KEY_EN, 4'h0);
    bus_wr(OFS_EXT_WAKE, 4'h0);
    instr(4'h2, sk);
    chk("swReset", 16'h4, 16'({coldRestart, backupFlag, inBackup}));
    @(posedge ref_clk);
    #1 chk("coldPulse", 16'h0, 16'(coldRestart));
    enter_bk();
    bus_rd(OFS_STATUS, d);
    chk("statusBackup", 16'h3, 16'(d));
    evt(4'h1, 3'b011);
    evt(4'h2, 3'b100);
    enter_bk();
    evt(4'h9, 3'b100);
    enter_bk();
    evt(4'hC, 3'b000);
  endtask

  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_poweroff();
    t_wake();
    t_cold();
    wrap_up();
  end

endmodule

`default_nettype wire
